// ===== ext_pin_irq_pkg.sv
// Purpose: Shared constants and carrier types for the external pin interrupt block
// Assumes: 8-bit register data on a plain strobe port, one clock at 125 MHz
// Notes:   Register offsets are byte addresses on the local register port
package ext_pin_irq_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;  // Pin control and event status
    localparam logic [7:0] OFS_INT_STATUS  = 8'h04;  // Sticky interrupt status, read clears
    localparam logic [7:0] OFS_INT_MASK    = 8'h08;  // Interrupt mask, same layout

    // Field positions of the control/status register
    localparam int BIT_DETECT_MODE   = 0;
    localparam int BIT_INT_ENABLE    = 1;
    localparam int BIT_EVENT_ACK     = 2;
    localparam int BIT_EVENT_FLAG    = 3;
    localparam int BIT_FUNC_ENABLE   = 4;
    localparam int BIT_POLARITY      = 5;
    localparam int BIT_PULL_DISABLE  = 6;
    localparam int BIT_UNIMPLEMENTED = 7;

    // Field positions of the interrupt status and mask registers
    localparam int BIT_IST_EVENT = 0;  // A qualifying pin event was seen
    localparam int BIT_IST_ACK   = 1;  // Software acknowledge cleared the flag
    localparam int IST_W         = 2;

    // Reset values
    localparam logic [7:0]       RST_CTRL_STATUS = 8'h00;
    localparam logic [IST_W-1:0] RST_INT_STATUS  = 2'h0;
    localparam logic [IST_W-1:0] RST_INT_MASK    = 2'h0;
    localparam logic [7:0]       RST_READ_DATA   = 8'h00;

    // Depth of the pin synchroniser
    localparam int SYNC_STAGES = 2;

    // One request on the register port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // Software-writable pin configuration
    typedef struct packed {
        logic pull_disable;
        logic polarity;
        logic func_enable;
        logic int_enable;
        logic detect_mode;
    } pin_cfg_t;

endpackage

// ===== external_pin_interrupt.sv
// Purpose: Request logic for one external interrupt pin with sticky flag and pull control
// Assumes: Pin input is asynchronous; register port is on clk_sys with reads answered next cycle
// Notes:   Edge detection runs on the synchronised pin, so events appear three edges late
//
// Contract
// RULE1 - Pin events recognised and pull controlled only while pin function is enabled.
// RULE2 - Polarity bit 0 selects falling/low, 1 selects rising/high as active.
// RULE3 - Mode 0 sets flag on active edges only; mode 1 also on active level.
// RULE4 - Read-only event flag at bit 3 sets on qualifying event and stays set.
// RULE5 - Writing 1 to acknowledge bit 2 clears flag; bit reads zero.
// RULE6 - In edge-and-level mode, acknowledge cannot clear flag while pin stays active.
// RULE7 - CPU request is high whenever flag and interrupt enable bit 1 are set.
// RULE8 - With pin enabled, pull-disable bit 6 switches the pull device off.
// RULE9 - With pin enabled and rising polarity, the pull device becomes a pulldown.
// RULE10 - Pin synchronised before detection; registers reset to zero; bit 7 reads zero.
`timescale 1ns/1ns

module external_pin_interrupt (
    input  wire logic                             clk_sys,       // 125 MHz system clock
    input  wire logic                             rst_b,         // Asynchronous reset, active low
    input  wire logic [ext_pin_irq_pkg::ADDR_W-1:0] reg_addr,    // Register byte address
    input  wire logic [ext_pin_irq_pkg::DATA_W-1:0] reg_wdata,   // Register write data
    input  wire logic                             reg_wr,        // Write strobe, one cycle
    input  wire logic                             reg_rd,        // Read strobe, one cycle
    output logic      [ext_pin_irq_pkg::DATA_W-1:0] reg_rdata,   // Read data, cycle after strobe
    input  wire logic                             pin_in,        // External interrupt pin level
    output logic                                  pin_cpu_req,   // Request to the CPU, level
    output logic                                  pull_enable,   // Internal pull device on
    output logic                                  pull_down_sel, // 1 pulldown, 0 pullup
    output logic                                  irq            // Masked sticky status interrupt
);

    // Decode helper shared by read and write paths
    function automatic logic hit(input logic [ext_pin_irq_pkg::ADDR_W-1:0] a,
                                 input logic [7:0]                          ofs);
        hit = (a == ofs);
    endfunction

    // Active sense of a pin level; shared so pin and its history use one polarity rule
    function automatic logic active_sense(input logic pol,
                                          input logic lvl);
        active_sense = pol ? lvl : ~lvl;
    endfunction

    ext_pin_irq_pkg::reg_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Pin synchroniser; only stage two is looked at by logic
    logic [ext_pin_irq_pkg::SYNC_STAGES-1:0] sync_r;
    logic [ext_pin_irq_pkg::SYNC_STAGES-1:0] sync_nxt;
    logic                                    pin_prev_r;
    logic                                    pin_prev_nxt;
    logic                                    pin_s;

    always_comb begin
        sync_nxt     = {sync_r[0], pin_in};  // RULE10
        pin_prev_nxt = sync_r[1];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_r     <= '0;
            pin_prev_r <= 1'b0;
        end else begin
            sync_r     <= sync_nxt;
            pin_prev_r <= pin_prev_nxt;
        end
    end

    assign pin_s = sync_r[1];

    // Event qualification on the synchronised pin
    ext_pin_irq_pkg::pin_cfg_t cfg_r;
    logic                      active_now;
    logic                      active_prev;
    logic                      active_edge;
    logic                      pin_event;
    logic                      level_hold;

    always_comb begin
        active_now  = active_sense(cfg_r.polarity, pin_s);       // RULE2
        active_prev = active_sense(cfg_r.polarity, pin_prev_r);  // RULE2
        active_edge = active_now & ~active_prev;
        // Level term only in edge-and-level mode
        pin_event   = cfg_r.func_enable &                         // RULE1
                      (active_edge | (cfg_r.detect_mode & active_now)); // RULE3
        // In edge-and-level mode an acknowledge is refused while the active level persists
        level_hold  = cfg_r.func_enable & cfg_r.detect_mode & active_now; // RULE6
    end

    // Register decode
    logic wr_ctrl;
    logic wr_mask;
    logic rd_ctrl;
    logic rd_ist;
    logic rd_mask;
    logic ack_wr;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_mask = 1'b0;
        rd_ctrl = 1'b0;
        rd_ist  = 1'b0;
        rd_mask = 1'b0;
        if (hit(req.addr, ext_pin_irq_pkg::OFS_CTRL_STATUS)) begin
            wr_ctrl = req.wr;
            rd_ctrl = req.rd;
        end else if (hit(req.addr, ext_pin_irq_pkg::OFS_INT_STATUS)) begin
            rd_ist  = req.rd;
        end else if (hit(req.addr, ext_pin_irq_pkg::OFS_INT_MASK)) begin
            wr_mask = req.wr;
            rd_mask = req.rd;
        end
        ack_wr = wr_ctrl & req.wdata[ext_pin_irq_pkg::BIT_EVENT_ACK];  // RULE5
    end

    // Configuration and event flag state
    ext_pin_irq_pkg::pin_cfg_t cfg_nxt;
    logic                      flag_r;
    logic                      flag_nxt;
    logic                      ack_done;

    always_comb begin
        cfg_nxt  = cfg_r;
        flag_nxt = flag_r;
        ack_done = 1'b0;
        if (wr_ctrl) begin
            cfg_nxt.pull_disable = req.wdata[ext_pin_irq_pkg::BIT_PULL_DISABLE];
            cfg_nxt.polarity     = req.wdata[ext_pin_irq_pkg::BIT_POLARITY];
            cfg_nxt.func_enable  = req.wdata[ext_pin_irq_pkg::BIT_FUNC_ENABLE];
            cfg_nxt.int_enable   = req.wdata[ext_pin_irq_pkg::BIT_INT_ENABLE];
            cfg_nxt.detect_mode  = req.wdata[ext_pin_irq_pkg::BIT_DETECT_MODE];
        end
        // Set wins over acknowledge so an event in the clearing cycle is kept
        if (pin_event) begin
            flag_nxt = 1'b1;                                      // RULE4
        end else if (ack_wr && !level_hold) begin
            flag_nxt = 1'b0;                                      // RULE5
            ack_done = flag_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r  <= '0;                                         // RULE10
            flag_r <= 1'b0;
        end else begin
            cfg_r  <= cfg_nxt;
            flag_r <= flag_nxt;
        end
    end

    // Sticky interrupt status with mask; a status read clears it
    logic [ext_pin_irq_pkg::IST_W-1:0] ist_r;
    logic [ext_pin_irq_pkg::IST_W-1:0] ist_nxt;
    logic [ext_pin_irq_pkg::IST_W-1:0] mask_r;
    logic [ext_pin_irq_pkg::IST_W-1:0] mask_nxt;
    logic [ext_pin_irq_pkg::IST_W-1:0] ist_set;

    always_comb begin
        ist_set = '0;
        ist_set[ext_pin_irq_pkg::BIT_IST_EVENT] = pin_event;
        ist_set[ext_pin_irq_pkg::BIT_IST_ACK]   = ack_done;
        ist_nxt  = (rd_ist ? '0 : ist_r) | ist_set;  // New events survive the clearing read
        mask_nxt = wr_mask ? req.wdata[ext_pin_irq_pkg::IST_W-1:0] : mask_r;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ist_r  <= ext_pin_irq_pkg::RST_INT_STATUS;
            mask_r <= ext_pin_irq_pkg::RST_INT_MASK;
        end else begin
            ist_r  <= ist_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Read mux and registered outputs
    logic [ext_pin_irq_pkg::DATA_W-1:0] rdata_nxt;
    logic                               cpu_req_nxt;
    logic                               pull_en_nxt;
    logic                               pull_dn_nxt;
    logic                               irq_nxt;

    always_comb begin
        rdata_nxt = ext_pin_irq_pkg::RST_READ_DATA;  // Unmapped reads return zero
        if (rd_ctrl) begin
            rdata_nxt[ext_pin_irq_pkg::BIT_PULL_DISABLE] = cfg_r.pull_disable;
            rdata_nxt[ext_pin_irq_pkg::BIT_POLARITY]     = cfg_r.polarity;
            rdata_nxt[ext_pin_irq_pkg::BIT_FUNC_ENABLE]  = cfg_r.func_enable;
            rdata_nxt[ext_pin_irq_pkg::BIT_EVENT_FLAG]   = flag_r;
            rdata_nxt[ext_pin_irq_pkg::BIT_INT_ENABLE]   = cfg_r.int_enable;
            rdata_nxt[ext_pin_irq_pkg::BIT_DETECT_MODE]  = cfg_r.detect_mode;
            // Acknowledge and bit 7 stay zero on read  // RULE5 RULE10
        end else if (rd_ist) begin
            rdata_nxt[ext_pin_irq_pkg::IST_W-1:0] = ist_r;
        end else if (rd_mask) begin
            rdata_nxt[ext_pin_irq_pkg::IST_W-1:0] = mask_r;
        end
        cpu_req_nxt = flag_nxt & cfg_nxt.int_enable;                         // RULE7
        pull_en_nxt = cfg_nxt.func_enable & ~cfg_nxt.pull_disable;           // RULE8
        pull_dn_nxt = cfg_nxt.func_enable & cfg_nxt.polarity;                // RULE9
        irq_nxt     = |(ist_nxt & mask_nxt);
    end

    // Request, pull and irq outputs follow the next state so they line up with the registers they reflect
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata     <= ext_pin_irq_pkg::RST_READ_DATA;
            pin_cpu_req   <= 1'b0;
            pull_enable   <= 1'b0;
            pull_down_sel <= 1'b0;
            irq           <= 1'b0;
        end else begin
            reg_rdata     <= rdata_nxt;
            pin_cpu_req   <= cpu_req_nxt;
            pull_enable   <= pull_en_nxt;
            pull_down_sel <= pull_dn_nxt;
            irq           <= irq_nxt;
        end
    end

    // Checks on the pin event path and register behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_quiet_disabled;
        !cfg_r.func_enable && !flag_r && !wr_ctrl;
    endsequence

    sequence s_fall_seen;
        cfg_r.func_enable && !cfg_r.polarity && pin_prev_r && !pin_s && !wr_ctrl;
    endsequence

    sequence s_rise_seen;
        cfg_r.func_enable && cfg_r.polarity && !pin_prev_r && pin_s && !wr_ctrl;
    endsequence

    // Acknowledge with nothing to hold the flag up
    sequence s_ack_clean;
        flag_r && ack_wr && !pin_event && !level_hold;
    endsequence

    // Acknowledge while the active level still stands in edge-and-level mode
    sequence s_ack_in_level;
        flag_r && ack_wr && level_hold;
    endsequence

    property p_disabled_no_event;
        s_quiet_disabled |=> !flag_r;
    endproperty
    a_disabled_no_event: assert property (p_disabled_no_event)  // RULE1
        else $error("Flag set while pin disabled");

    property p_polarity_edges;
        (s_fall_seen or s_rise_seen) |=> flag_r ##0 pin_cpu_req == cfg_r.int_enable;
    endproperty
    a_polarity_edges: assert property (p_polarity_edges)  // RULE2
        else $error("Active edge did not set flag");

    property p_edge_only_mode;
        (cfg_r.func_enable && !cfg_r.detect_mode && !flag_r && !wr_ctrl
         && pin_s == pin_prev_r) |=> !flag_r;
    endproperty
    a_edge_only_mode: assert property (p_edge_only_mode)  // RULE3
        else $error("Flag set without edge in edge mode");

    property p_level_sets;
        (cfg_r.func_enable && cfg_r.detect_mode && active_now) |=> flag_r;
    endproperty
    a_level_sets: assert property (p_level_sets)  // RULE3
        else $error("Active level did not set flag");

    property p_flag_sticky;
        (flag_r && !ack_wr) |=> flag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)  // RULE4
        else $error("Flag dropped without acknowledge");

    property p_flag_readback;
        rd_ctrl |=> reg_rdata[ext_pin_irq_pkg::BIT_EVENT_FLAG] == $past(flag_r);
    endproperty
    a_flag_readback: assert property (p_flag_readback)  // RULE4
        else $error("Flag read back wrong");

    // Status bits are the event record behind the level interrupt
    property p_status_read_clears;
        (rd_ist && !pin_event && !ack_done) |=> ist_r == '0;
    endproperty
    a_status_read_clears: assert property (p_status_read_clears)  // RULE4
        else $error("Status read did not clear");

    property p_irq_level;
        irq == (|(ist_r & mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level)  // RULE4
        else $error("Interrupt level does not match status and mask");

    property p_ack_clears;
        s_ack_clean |=> !flag_r;
    endproperty
    a_ack_clears: assert property (p_ack_clears)  // RULE5
        else $error("Acknowledge did not clear flag");

    property p_ack_reports;
        s_ack_clean |=> ist_r[ext_pin_irq_pkg::BIT_IST_ACK];
    endproperty
    a_ack_reports: assert property (p_ack_reports)  // RULE5
        else $error("Cleared flag not reported in status");

    property p_ack_reads_zero;
        rd_ctrl |=> !reg_rdata[ext_pin_irq_pkg::BIT_EVENT_ACK] && !reg_rdata[ext_pin_irq_pkg::BIT_UNIMPLEMENTED];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)  // RULE5
        else $error("Acknowledge or bit 7 read nonzero");

    property p_level_holds;
        s_ack_in_level |=> flag_r;
    endproperty
    a_level_holds: assert property (p_level_holds)  // RULE6
        else $error("Flag cleared while level active");

    property p_cpu_request;
        (flag_r && cfg_r.int_enable) |-> pin_cpu_req;
    endproperty
    a_cpu_request: assert property (p_cpu_request)  // RULE7
        else $error("CPU request missing with flag set");

    property p_cpu_request_off;
        !(flag_r && cfg_r.int_enable) |-> !pin_cpu_req;
    endproperty
    a_cpu_request_off: assert property (p_cpu_request_off)  // RULE7
        else $error("CPU request without flag and enable");

    property p_pull_control;
        pull_enable |-> cfg_r.func_enable && !cfg_r.pull_disable;
    endproperty
    a_pull_control: assert property (p_pull_control)  // RULE8
        else $error("Pull on while disabled");

    property p_pull_on;
        (cfg_r.func_enable && !cfg_r.pull_disable) |-> pull_enable;
    endproperty
    a_pull_on: assert property (p_pull_on)  // RULE8
        else $error("Pull off while enabled");

    property p_pulldown;
        pull_down_sel |-> cfg_r.func_enable && cfg_r.polarity;
    endproperty
    a_pulldown: assert property (p_pulldown)  // RULE9
        else $error("Pulldown selected wrongly");

    property p_sync_latency;
        (cfg_r.func_enable && !cfg_r.detect_mode && !flag_r && $stable(pin_in)
         && pin_s == pin_in && pin_prev_r == pin_in && !wr_ctrl) |=> !flag_r;
    endproperty
    a_sync_latency: assert property (p_sync_latency)  // RULE10
        else $error("Flag set with steady pin");

endmodule  // external_pin_interrupt

// ===== pin_source.sv
// Purpose: Behavioural source that stands on the external interrupt pin
// Assumes: Bench sets drive_en/drive_lvl by non-blocking assignment at the rising edge
// Notes:   An undriven pin follows the block's pull device, or wanders if no pull is on
`timescale 1ns/1ns

module pin_source (
    input  wire logic clk_sys,       // System clock
    input  wire logic drive_en,      // Source drives the pin
    input  wire logic drive_lvl,     // Level driven when enabled
    input  wire logic pull_enable,   // Pull device on, from the block
    input  wire logic pull_down_sel, // 1 pulldown, 0 pullup
    output logic      pin_in         // Pin level seen by the block
);
    // Pin changes off the sampling instant, so the synchroniser sees a truly async input
    initial pin_in = 1'b1;
    always @(posedge clk_sys) begin
        #3;
        if (drive_en)
            pin_in = drive_lvl;
        else if (pull_enable)
            pin_in = ~pull_down_sel;
        else
            pin_in = ~pin_in; // Floating pin: never a stable value to lean on
    end
endmodule // pin_source

// ===== tb_top.sv
// Purpose: Self-checking bench for the external pin interrupt block
// Assumes: Register port answers reads in the cycle after the strobe
// Notes:   A pin change reaches the flag within three cycles, which every wait allows for
`timescale 1ns/1ns

module tb_top;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       pin_in;
    logic       pin_cpu_req;
    logic       pull_enable;
    logic       pull_down_sel;
    logic       irq;
    logic       drv_en = 1'b1;
    logic       drv_lvl = 1'b1;
    int         n_errors = 0;
    int         n_checks = 0;
    int         cyc = 0;
    logic [7:0] d;

    external_pin_interrupt i_external_pin_interrupt (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_cpu_req(pin_cpu_req), .pull_enable(pull_enable), .pull_down_sel(pull_down_sel), .irq(irq));
    pin_source i_pin_source (.clk_sys(clk_sys), .drive_en(drv_en), .drive_lvl(drv_lvl),
        .pull_enable(pull_enable), .pull_down_sel(pull_down_sel), .pin_in(pin_in));

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    // Hang guard, far beyond the few hundred cycles the scenarios need
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wcyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Control byte from its fields
    function automatic logic [7:0] mk(input logic md, ie, fe, pol, pd);
        mk = 8'h00;
        mk[ext_pin_irq_pkg::BIT_DETECT_MODE] = md;
        mk[ext_pin_irq_pkg::BIT_INT_ENABLE] = ie;
        mk[ext_pin_irq_pkg::BIT_FUNC_ENABLE] = fe;
        mk[ext_pin_irq_pkg::BIT_POLARITY] = pol;
        mk[ext_pin_irq_pkg::BIT_PULL_DISABLE] = pd;
    endfunction

    task automatic pin(input logic lvl);
        @(posedge clk_sys);
        drv_lvl <= lvl;
        wcyc(7);
    endtask

    task automatic flag(input logic exp);
        rd(ext_pin_irq_pkg::OFS_CTRL_STATUS, d);
        chk({7'h00, d[ext_pin_irq_pkg::BIT_EVENT_FLAG]}, {7'h00, exp});
    endtask

    task automatic t_reset();
        rd(ext_pin_irq_pkg::OFS_CTRL_STATUS, d);
        chk(d, 8'h00);
        chk({5'h00, pin_cpu_req, pull_enable, pull_down_sel}, 8'h00);
        // Edge-only mode, so the pin already high does not set the flag on enable
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, 8'hf6);
        rd(ext_pin_irq_pkg::OFS_CTRL_STATUS, d);
        chk(d, 8'h72);
        chk({6'h00, pull_enable, pull_down_sel}, 8'h01);
    endtask

    // Edge mode for both polarities: sticky flag, acknowledge, request, pull
    task automatic t_edge(input logic pol);
        pin(~pol);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 1, 1, pol, 0) | 8'h04);
        wcyc(1);
        chk({6'h00, pull_enable, pull_down_sel}, {7'h00, 1'b1} << 1 | {7'h00, pol});
        flag(0);
        pin(pol);
        flag(1);
        chk({7'h00, pin_cpu_req}, 8'h01);
        pin(~pol);
        flag(1);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 1, 1, pol, 0));
        flag(1);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 0, 1, pol, 0) | 8'h04);
        wcyc(1);
        chk({7'h00, pin_cpu_req}, 8'h00);
        flag(0);
        pin(pol);
        wcyc(1);
        chk({7'h00, pin_cpu_req}, 8'h00);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 0, 1, pol, 0) | 8'h04);
        pin(~pol);
    endtask

    // Level mode keeps the flag while the pin stays active; edge mode does not
    task automatic t_level();
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(1, 1, 1, 0, 0));
        pin(0);
        flag(1);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(1, 1, 1, 0, 0) | 8'h04);
        wcyc(2);
        flag(1);
        pin(1);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(1, 1, 1, 0, 0) | 8'h04);
        flag(0);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 1, 1, 0, 0));
        pin(0);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 1, 1, 0, 0) | 8'h04);
        wcyc(3);
        flag(0);
        pin(1);
    endtask

    // Disabled pin: no flag and pull off, even with the line floating and toggling
    task automatic t_disabled();
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(1, 1, 0, 1, 0));
        @(posedge clk_sys);
        drv_en <= 1'b0;
        wcyc(12);
        chk({6'h00, pull_enable, pull_down_sel}, 8'h00);
        flag(0);
        chk({7'h00, pin_cpu_req}, 8'h00);
        @(posedge clk_sys);
        drv_en <= 1'b1;
    endtask

    // Sticky status, mask, read clear, refused places
    task automatic t_irq();
        rd(ext_pin_irq_pkg::OFS_INT_STATUS, d);
        wr(ext_pin_irq_pkg::OFS_INT_STATUS, 8'hff);
        rd(ext_pin_irq_pkg::OFS_INT_STATUS, d);
        chk(d, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, d);
        chk(d, 8'h00);
        wr(ext_pin_irq_pkg::OFS_INT_MASK, 8'h03);
        rd(ext_pin_irq_pkg::OFS_INT_MASK, d);
        chk(d, 8'h03);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 0, 1, 0, 1));
        wcyc(1);
        chk({7'h00, irq}, 8'h00);
        pin(0);
        chk({6'h00, irq, pin_cpu_req}, 8'h02);
        rd(ext_pin_irq_pkg::OFS_INT_STATUS, d);
        chk(d, 8'h01);
        wcyc(2);
        chk({7'h00, irq}, 8'h00);
        pin(1);
        wr(ext_pin_irq_pkg::OFS_CTRL_STATUS, mk(0, 0, 1, 0, 1) | 8'h04);
        wcyc(2);
        chk({7'h00, irq}, 8'h01);
        rd(ext_pin_irq_pkg::OFS_INT_STATUS, d);
        chk(d, 8'h02);
        wr(ext_pin_irq_pkg::OFS_INT_MASK, 8'h00);
        pin(0);
        chk({7'h00, irq}, 8'h00);
        flag(1);
    endtask

    // Mid-run reset brings flag, config and mask back to zero
    task automatic t_rerst();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        wcyc(3);
        chk({5'h00, irq, pin_cpu_req, pull_enable}, 8'h00);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ext_pin_irq_pkg::OFS_CTRL_STATUS, d);
        chk(d, 8'h00);
        rd(ext_pin_irq_pkg::OFS_INT_MASK, d);
        chk(d, 8'h00);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_edge(0);
        t_edge(1);
        t_level();
        t_disabled();
        t_irq();
        t_rerst();
        end_sim();
    end
endmodule // tb_top
